// *** mpm_pkg.sv ***
package mpm_pkg;

   // ---------------------------------------------------------------
   // register area split
   // ---------------------------------------------------------------
   localparam logic [15:0] USER_FIRST = 16'h0001;
   localparam logic [15:0] USER_LAST = 16'h0100;
   localparam logic [15:0] RSVD_LAST = 16'h0210;
   localparam logic [15:0] FIXED_BASE = 16'h0211;
   localparam logic [15:0] PNUM_FIRST = 16'h0001;

   // ---------------------------------------------------------------
   // connection handling
   // ---------------------------------------------------------------
   localparam logic [15:0] TCP_PORT = 16'h01F6;
   localparam logic [1:0] MAX_CONN = 2'h3;

   // ---------------------------------------------------------------
   // encodings
   // ---------------------------------------------------------------
   // address space of a request as delivered by the server
   typedef enum logic [1:0] {
      SP_COIL = 2'h0,
      SP_DISC = 2'h1,
      SP_INPUT = 2'h2,
      SP_HOLD = 2'h3
   } mpm_space_t;

   // size class of a parameter as reported by the store
   typedef enum logic [1:0] {
      KIND_B1 = 2'h0,
      KIND_B2 = 2'h1,
      KIND_B4 = 2'h2,
      KIND_STR = 2'h3
   } mpm_kind_t;

   typedef enum logic [1:0] {
      RT_NONE = 2'h0,
      RT_USER = 2'h1,
      RT_RSVD = 2'h2,
      RT_FIXED = 2'h3
   } mpm_route_t;

endpackage : mpm_pkg

// *** mpm_map_if.sv ***
`timescale 1ns/1ps
interface mpm_map_if;
   logic [15:0] reg_num;
   mpm_pkg::mpm_route_t route;
   logic [15:0] pnum;
   logic second;
   mpm_pkg::mpm_kind_t kind;
   logic [31:0] data;
   logic hwf;
   logic [15:0] rd_word;

   modport dec (input reg_num, output route, output pnum, output second);
   modport pack (input kind, input data, input hwf, input second, output rd_word);
   modport core (output reg_num, output kind, output data, output hwf,
                 input route, input pnum, input second, input rd_word);
endinterface : mpm_map_if

// *** mpm_addr_dec.sv ***
`timescale 1ns/1ps
module mpm_addr_dec (
   // decode fields
   mpm_map_if.dec m
);

   logic [15:0] off;

   // ---------------------------------------------------------------
   // area split and fixed formula
   // ---------------------------------------------------------------
   // two registers per parameter: first register is 2*(p-1)+base
   always_comb
   begin
      off = m.reg_num - mpm_pkg::FIXED_BASE;
      m.pnum = {1'b0, off[15:1]} + mpm_pkg::PNUM_FIRST;
      m.second = off[0];
      if (m.reg_num < mpm_pkg::USER_FIRST)
         m.route = mpm_pkg::RT_NONE;
      else if (m.reg_num <= mpm_pkg::USER_LAST)
         m.route = mpm_pkg::RT_USER;
      else if (m.reg_num <= mpm_pkg::RSVD_LAST)
         m.route = mpm_pkg::RT_RSVD;
      else
         m.route = mpm_pkg::RT_FIXED;
   end

endmodule : mpm_addr_dec

// *** mpm_word_pack.sv ***
`timescale 1ns/1ps
module mpm_word_pack (
   // packing fields
   mpm_map_if.pack m
);

   // ---------------------------------------------------------------
   // value to register placement
   // ---------------------------------------------------------------
   // strings bypass word order: byte 0 is the lowest-addressed char
   always_comb
   begin
      unique case (m.kind)
         mpm_pkg::KIND_B1:
            m.rd_word = m.second ? 16'h0000 : {8'h00, m.data[7:0]};
         mpm_pkg::KIND_B2:
            m.rd_word = m.second ? 16'h0000 : m.data[15:0];
         mpm_pkg::KIND_B4:
            m.rd_word = (m.second ^ m.hwf) ? m.data[31:16] : m.data[15:0];
         mpm_pkg::KIND_STR:
            m.rd_word = m.second ? m.data[31:16] : m.data[15:0];
      endcase
   end

endmodule : mpm_word_pack

// *** mpm_top.sv ***
`timescale 1ns/1ps
module mpm_top (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_i,
   // connection management
   input wire logic conn_open_i,
   input wire logic [15:0] conn_port_i,
   input wire logic conn_close_i,
   input wire logic [7:0] max_conn_i,
   output logic conn_accept_o,
   output logic conn_refuse_o,
   output logic [1:0] conn_count_o,
   // settings
   input wire logic high_word_first_i,
   // register request from server
   input wire logic req_valid_i,
   output logic req_ready_o,
   input wire logic [1:0] req_space_i,
   input wire logic req_write_i,
   input wire logic req_last_i,
   input wire logic [15:0] req_addr_i,
   input wire logic [15:0] req_wdata_i,
   // register answer to server
   output logic rsp_valid_o,
   output logic [15:0] rsp_data_o,
   output logic rsp_err_o,
   // parameter store
   output logic st_req_o,
   output logic st_write_o,
   output logic st_user_o,
   output logic [15:0] st_index_o,
   output logic [31:0] st_wdata_o,
   input wire logic st_ack_i,
   input wire logic [1:0] st_kind_i,
   input wire logic [31:0] st_rdata_i
);

   typedef enum {S_IDLE, S_RD, S_WR, S_RSP} mpm_state_t;

   typedef struct packed {
      mpm_state_t st;
      logic [1:0] conn_cnt;
      logic accept;
      logic refuse;
      logic [15:0] addr;
      logic write;
      logic [15:0] wdata;
      logic last;
      logic rsp_err;
      logic [15:0] rsp_data;
      logic st_req;
      logic st_write;
      logic st_user;
      logic [15:0] st_index;
      logic [31:0] st_wdata;
      logic pend_valid;
      logic [15:0] pend_pnum;
      logic [15:0] pend_word;
   } mpm_core_t;

   mpm_core_t q_r;
   mpm_core_t q_nxt;
   logic take;
   logic open_ok;
   logic bad_space;
   logic rd_ack;
   mpm_pkg::mpm_kind_t kind;

   mpm_map_if m ();

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   mpm_addr_dec u_dec (
      .m (m.dec)
   );

   mpm_word_pack u_pack (
      .m (m.pack)
   );

   // decode the live address while idle, the held one afterwards
   assign m.reg_num = (q_r.st == S_IDLE) ? req_addr_i : q_r.addr;
   assign kind = mpm_pkg::mpm_kind_t'(st_kind_i);
   assign m.kind = kind;
   assign m.data = st_rdata_i;
   assign m.hwf = high_word_first_i;

   assign take = req_valid_i && req_ready_o;
   assign bad_space = (req_space_i == mpm_pkg::SP_COIL) || (req_space_i == mpm_pkg::SP_DISC);
   assign rd_ack = (q_r.st == S_RD) && st_ack_i;

   // connection may open only on the service port, within both limits
   assign open_ok = conn_open_i && (conn_port_i == mpm_pkg::TCP_PORT)
                    && (max_conn_i != 8'h00)
                    && ({6'h00, q_r.conn_cnt} < max_conn_i)
                    && (q_r.conn_cnt < mpm_pkg::MAX_CONN);

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb
   begin
      q_nxt = q_r;
      q_nxt.accept = open_ok;
      q_nxt.refuse = conn_open_i && !open_ok;
      if (open_ok && !(conn_close_i && q_r.conn_cnt != 2'h0))
         q_nxt.conn_cnt = q_r.conn_cnt + 2'h1;
      else if (!open_ok && conn_close_i && q_r.conn_cnt != 2'h0)
         q_nxt.conn_cnt = q_r.conn_cnt - 2'h1;
      unique case (q_r.st)
         S_IDLE:
         begin
            if (take)
            begin
               q_nxt.addr = req_addr_i;
               q_nxt.write = req_write_i;
               q_nxt.wdata = req_wdata_i;
               q_nxt.last = req_last_i;
               q_nxt.rsp_err = 1'b0;
               q_nxt.rsp_data = 16'h0000;
               q_nxt.st_index = m.pnum;
               q_nxt.st_user = 1'b0;
               q_nxt.st_write = 1'b0;
               q_nxt.st_wdata = {16'h0000, req_wdata_i};
               if (bad_space || m.route == mpm_pkg::RT_NONE)
               begin
                  q_nxt.rsp_err = 1'b1;
                  q_nxt.st = S_RSP;
               end
               else if (m.route == mpm_pkg::RT_RSVD)
                  q_nxt.st = S_RSP; // reserved area: reads zero, writes dropped
               else if (m.route == mpm_pkg::RT_USER)
               begin
                  // the user map owns placement of its registers
                  q_nxt.st_user = 1'b1;
                  q_nxt.st_index = req_addr_i - mpm_pkg::USER_FIRST;
                  q_nxt.st_write = req_write_i;
                  q_nxt.st_req = 1'b1;
                  q_nxt.st = req_write_i ? S_WR : S_RD;
               end
               else
               begin
                  // element and fragment numbers are plain parameter numbers
                  q_nxt.st_req = 1'b1;
                  q_nxt.st = S_RD;
               end
            end
         end
         S_RD:
         begin
            if (st_ack_i)
            begin
               q_nxt.st_req = 1'b0;
               q_nxt.st = S_RSP;
               if (q_r.st_user)
                  q_nxt.rsp_data = st_rdata_i[15:0];
               else if (!q_r.write)
                  q_nxt.rsp_data = m.rd_word; // whole-array number sees 4 bytes
               else if (kind == mpm_pkg::KIND_B1 && !m.second)
               begin
                  q_nxt.st_wdata = {24'h000000, q_r.wdata[7:0]};
                  q_nxt.st_write = 1'b1;
               end
               else if (kind == mpm_pkg::KIND_B2 && !m.second)
               begin
                  q_nxt.st_wdata = {16'h0000, q_r.wdata};
                  q_nxt.st_write = 1'b1;
               end
               else if (kind == mpm_pkg::KIND_B1 || kind == mpm_pkg::KIND_B2)
                  q_nxt.pend_valid = 1'b0; // unused second register ignores write
               else if (!m.second)
               begin
                  // hold the first half; nothing reaches the store yet
                  q_nxt.pend_valid = 1'b1;
                  q_nxt.pend_pnum = m.pnum;
                  q_nxt.pend_word = q_r.wdata;
               end
               else if (q_r.pend_valid && q_r.pend_pnum == m.pnum)
               begin
                  q_nxt.st_write = 1'b1; // both halves in one request
                  q_nxt.pend_valid = 1'b0;
                  if (kind == mpm_pkg::KIND_STR || !high_word_first_i)
                     q_nxt.st_wdata = {q_r.wdata, q_r.pend_word};
                  else
                     q_nxt.st_wdata = {q_r.pend_word, q_r.wdata};
               end
               else
                  q_nxt.pend_valid = 1'b0; // lone second half is dropped
               if (q_nxt.st_write)
               begin
                  q_nxt.st_req = 1'b1;
                  q_nxt.st = S_WR;
               end
            end
         end
         S_WR:
         begin
            if (st_ack_i)
            begin
               q_nxt.st_req = 1'b0;
               q_nxt.st_write = 1'b0;
               q_nxt.st = S_RSP;
            end
         end
         S_RSP:
         begin
            // a half left over at the end of a request never commits
            if (q_r.last)
               q_nxt.pend_valid = 1'b0;
            q_nxt.st_write = 1'b0;
            q_nxt.st = S_IDLE;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         q_r <= '0;
         q_r.st <= S_IDLE;
      end
      else
         q_r <= q_nxt;
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign req_ready_o = (q_r.st == S_IDLE);
   assign rsp_valid_o = (q_r.st == S_RSP);
   assign rsp_data_o = q_r.rsp_data;
   assign rsp_err_o = q_r.rsp_err;
   assign conn_accept_o = q_r.accept;
   assign conn_refuse_o = q_r.refuse;
   assign conn_count_o = q_r.conn_cnt;
   assign st_req_o = q_r.st_req;
   assign st_write_o = q_r.st_write;
   assign st_user_o = q_r.st_user;
   assign st_index_o = q_r.st_index;
   assign st_wdata_o = q_r.st_wdata;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (rst_i);

   sequence s_take_fixed;
      take && !bad_space && req_addr_i > mpm_pkg::RSVD_LAST;
   endsequence

   sequence s_take_user;
      take && !bad_space && req_addr_i != 16'h0000 && req_addr_i <= mpm_pkg::USER_LAST;
   endsequence

   sequence s_fixed_read_ack;
      rd_ack && !q_r.write && !q_r.st_user;
   endsequence

   a_conn_limit: assert property (conn_count_o <= mpm_pkg::MAX_CONN)
      else $error("more open connections than allowed");

   a_port_only: assert property (conn_accept_o |-> $past(conn_port_i) == mpm_pkg::TCP_PORT)
      else $error("connection accepted on wrong port");

   a_zero_limit: assert property (conn_open_i && max_conn_i == 8'h00 |=> conn_refuse_o && !conn_accept_o)
      else $error("connection not refused with zero limit");

   a_coil_error: assert property (take && bad_space |=> rsp_valid_o && rsp_err_o ##1 req_ready_o)
      else $error("coil or discrete request not answered with error");

   a_user_route: assert property (s_take_user |=> st_req_o && st_user_o && st_index_o == $past(req_addr_i) - 16'h0001)
      else $error("user area not routed to user map");

   a_fixed_index: assert property (s_take_fixed |=> st_req_o && !st_user_o && st_index_o == (($past(req_addr_i) - mpm_pkg::FIXED_BASE) >> 1) + 16'h0001)
      else $error("fixed register maps to wrong parameter");

   a_byte_high: assert property (s_fixed_read_ack and (kind == mpm_pkg::KIND_B1 && !m.second) |=> rsp_data_o == {8'h00, $past(st_rdata_i[7:0])})
      else $error("one-byte parameter not zero extended");

   a_unused_zero: assert property (s_fixed_read_ack and (m.second && (kind == mpm_pkg::KIND_B1 || kind == mpm_pkg::KIND_B2)) |=> rsp_data_o == 16'h0000)
      else $error("unused register read not zero");

   a_word_order: assert property (s_fixed_read_ack and (kind == mpm_pkg::KIND_B4 && !m.second && high_word_first_i) |=> rsp_data_o == $past(st_rdata_i[31:16]))
      else $error("high word not first");

   a_half_hold: assert property (rd_ack && q_r.write && !q_r.st_user && kind == mpm_pkg::KIND_B4 && !m.second |=> !st_req_o ##1 !st_req_o)
      else $error("half write reached the store");

   a_string_low: assert property (s_fixed_read_ack and (kind == mpm_pkg::KIND_STR && !m.second) |=> rsp_data_o == $past(st_rdata_i[15:0]))
      else $error("string not packed low byte first");

endmodule : mpm_top

// *** mpm_store_model.sv ***
`timescale 1ns/1ps
module mpm_store_model (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_i,
   // behaviour control
   input wire logic slow_i,
   // store port
   input wire logic st_req_i,
   input wire logic st_write_i,
   input wire logic st_user_i,
   input wire logic [15:0] st_index_i,
   input wire logic [31:0] st_wdata_i,
   output logic st_ack_o,
   output logic [1:0] st_kind_o,
   output logic [31:0] st_rdata_o,
   output int wr_count_o
);
   logic [31:0] mem [16];
   logic [1:0] wait_r;

   // ---------------------------------------------------------------
   // storage preset: every byte differs so misplaced bytes show
   // ---------------------------------------------------------------
   initial
   begin
      for (int i = 0; i < 16; i++)
         mem[i] = 32'h40506070 + {4{8'(i)}};
   end

   // one ack per request, never in the cycle after an ack
   always @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         st_ack_o <= 1'b0;
         wait_r <= 2'h0;
         wr_count_o <= 0;
         // known kind from reset keeps the size decode out of unknowns
         st_kind_o <= 2'h0;
         st_rdata_o <= 32'h00000000;
      end
      else if (st_ack_o)
      begin
         st_ack_o <= 1'b0;
         st_rdata_o <= ~st_rdata_o;
         st_kind_o <= ~st_kind_o;
      end
      else if (st_req_i && wait_r == (slow_i ? 2'h3 : 2'h0))
      begin
         st_ack_o <= 1'b1;
         wait_r <= 2'h0;
         // element and fragment numbers resolve here, low bits pick size class
         st_kind_o <= st_user_i ? 2'h1 : st_index_i[1:0];
         st_rdata_o <= mem[st_index_i[3:0]];
         if (st_write_i)
         begin
            mem[st_index_i[3:0]] <= st_wdata_i;
            wr_count_o <= wr_count_o + 1;
         end
      end
      else if (st_req_i)
         wait_r <= wait_r + 2'h1;
      else
         st_rdata_o <= ~st_rdata_o; // idle data never holds the last value
   end
endmodule : mpm_store_model

// *** mpm_top_tb.sv ***
`timescale 1ns/1ps
module mpm_top_tb;
   logic clk_sys_i = 1'b0;
   logic rst_i = 1'b1;
   logic conn_open_i = 1'b0;
   logic [15:0] conn_port_i = 16'h0000;
   logic conn_close_i = 1'b0;
   logic [7:0] max_conn_i = 8'h00;
   logic high_word_first_i = 1'b0;
   logic req_valid_i = 1'b0;
   logic [1:0] req_space_i = 2'h3;
   logic req_write_i = 1'b0;
   logic req_last_i = 1'b0;
   logic [15:0] req_addr_i = 16'h0000;
   logic [15:0] req_wdata_i = 16'h0000;
   logic slow = 1'b0;
   logic conn_accept_o, conn_refuse_o, req_ready_o, rsp_valid_o, rsp_err_o;
   logic st_req_o, st_write_o, st_user_o, st_ack_i;
   logic [1:0] conn_count_o, st_kind_i;
   logic [15:0] rsp_data_o, st_index_o;
   logic [31:0] st_wdata_o, st_rdata_i;
   int wr_count;
   int failures = 0;
   int samples_checked = 0;
   logic [16:0] eq [$];
   logic [3:0] cq [$];
   logic [31:0] em [16];

   always #2 clk_sys_i = ~clk_sys_i;

   mpm_top i_mpm_top (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .conn_open_i(conn_open_i),
      .conn_port_i(conn_port_i), .conn_close_i(conn_close_i), .max_conn_i(max_conn_i),
      .conn_accept_o(conn_accept_o), .conn_refuse_o(conn_refuse_o),
      .conn_count_o(conn_count_o), .high_word_first_i(high_word_first_i),
      .req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .req_space_i(req_space_i),
      .req_write_i(req_write_i), .req_last_i(req_last_i), .req_addr_i(req_addr_i),
      .req_wdata_i(req_wdata_i), .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o),
      .rsp_err_o(rsp_err_o), .st_req_o(st_req_o), .st_write_o(st_write_o),
      .st_user_o(st_user_o), .st_index_o(st_index_o), .st_wdata_o(st_wdata_o),
      .st_ack_i(st_ack_i), .st_kind_i(st_kind_i), .st_rdata_i(st_rdata_i));

   mpm_store_model i_mpm_store_model (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .slow_i(slow),
      .st_req_i(st_req_o), .st_write_i(st_write_o), .st_user_i(st_user_o),
      .st_index_i(st_index_o), .st_wdata_i(st_wdata_o), .st_ack_o(st_ack_i),
      .st_kind_o(st_kind_i), .st_rdata_o(st_rdata_i), .wr_count_o(wr_count));

   // ---------------------------------------------------------------
   // expectations, kept apart from the store model's own copy
   // ---------------------------------------------------------------
   function automatic logic [15:0] exp_fix(input logic [15:0] a, input logic hwf);
      logic [15:0] off;
      logic [15:0] p;
      logic [31:0] v;
      off = a - 16'h0211;
      p = (off >> 1) + 16'h0001;
      v = em[p[3:0]];
      case (p[1:0])
         2'h0: exp_fix = off[0] ? 16'h0000 : {8'h00, v[7:0]};
         2'h1: exp_fix = off[0] ? 16'h0000 : v[15:0];
         2'h2: exp_fix = (off[0] ^ hwf) ? v[31:16] : v[15:0];
         default: exp_fix = off[0] ? v[31:16] : v[15:0];
      endcase
   endfunction : exp_fix

   task automatic results();
      $display("checked %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : results

   task automatic chk_rsp();
      logic [16:0] e;
      e = (eq.size() != 0) ? eq.pop_front() : 17'h1FFFF;
      samples_checked++;
      if ({rsp_err_o, rsp_data_o} !== e)
      begin
         failures++;
         $display("[ERR] %0t answer got %h exp %h", $time, {rsp_err_o, rsp_data_o}, e);
      end
   endtask : chk_rsp

   task automatic chk_conn();
      logic [3:0] e;
      e = (cq.size() != 0) ? cq.pop_front() : 4'hF;
      samples_checked++;
      if ({conn_accept_o, conn_refuse_o, conn_count_o} !== e)
      begin
         failures++;
         $display("[ERR] %0t connection got %b exp %b", $time,
                  {conn_accept_o, conn_refuse_o, conn_count_o}, e);
      end
   endtask : chk_conn

   task automatic chk_wr(input int e);
      samples_checked++;
      if (wr_count != e)
      begin
         failures++;
         $display("[ERR] %0t store writes %0d exp %0d", $time, wr_count, e);
      end
   endtask : chk_wr

   // outputs are settled at the falling edge; results stand one cycle
   always @(negedge clk_sys_i)
   begin
      if (!rst_i && rsp_valid_o === 1'b1)
         chk_rsp();
      if (!rst_i && (conn_accept_o | conn_refuse_o) === 1'b1)
         chk_conn();
   end

   // request held from a falling edge until the edge that sees ready
   task automatic acc(input logic [1:0] sp, input logic wr, input logic lst,
                      input logic [15:0] a, input logic [15:0] wd,
                      input logic [15:0] ed, input logic ee);
      int n;
      n = 0;
      eq.push_back({ee, ed});
      @(negedge clk_sys_i);
      req_valid_i = 1'b1;
      req_space_i = sp;
      req_write_i = wr;
      req_last_i = lst;
      req_addr_i = a;
      req_wdata_i = wd;
      while (req_ready_o !== 1'b1 && n < 50)
      begin
         @(negedge clk_sys_i);
         n++;
      end
      if (n == 50)
         failures++;
      @(negedge clk_sys_i);
      req_valid_i = 1'b0;
   endtask : acc

   task automatic conn(input logic op, input logic cl, input logic [15:0] port,
                       input logic [7:0] mx, input logic [3:0] e);
      if (op)
         cq.push_back(e);
      @(negedge clk_sys_i);
      conn_open_i = op;
      conn_close_i = cl;
      conn_port_i = port;
      max_conn_i = mx;
      @(negedge clk_sys_i);
      conn_open_i = 1'b0;
      conn_close_i = 1'b0;
   endtask : conn

   // waits until every answer is in and the block is idle
   task automatic drain();
      int n;
      n = 0;
      while ((eq.size() != 0 || req_ready_o !== 1'b1) && n < 100)
      begin
         @(negedge clk_sys_i);
         n++;
      end
      if (n == 100)
         failures++;
   endtask : drain

   // watchdog sized well above the planned traffic
   initial
   begin
      #200000;
      failures++;
      results();
   end

   initial
   begin
      logic [15:0] w0, w1, a;
      int wc;
      for (int i = 0; i < 16; i++)
         em[i] = 32'h40506070 + {4{8'(i)}};
      void'($urandom(32'hD1E3));
      repeat (2) @(posedge clk_sys_i);
      @(negedge clk_sys_i);
      rst_i = 1'b0;
      conn(1'b1, 1'b0, 16'h01F6, 8'h00, 4'b0100);
      conn(1'b1, 1'b0, 16'h01F7, 8'h08, 4'b0100);
      for (int i = 1; i <= 3; i++)
         conn(1'b1, 1'b0, 16'h01F6, 8'h08, {2'b10, 2'(i)});
      conn(1'b1, 1'b0, 16'h01F6, 8'h08, 4'b0111);
      conn(1'b0, 1'b1, 16'h01F6, 8'h08, 4'b0000);
      conn(1'b1, 1'b0, 16'h01F6, 8'h02, 4'b0110);
      conn(1'b1, 1'b0, 16'h01F6, 8'h08, 4'b1011);
      conn(1'b1, 1'b1, 16'h01F6, 8'h08, 4'b0110);
      conn(1'b1, 1'b1, 16'h01F6, 8'h08, 4'b1010);
      $display("test connections done");
      acc(2'h0, 1'b0, 1'b1, 16'h0211, 16'h0000, 16'h0000, 1'b1);
      acc(2'h1, 1'b0, 1'b1, 16'h0211, 16'h0000, 16'h0000, 1'b1);
      acc(2'h3, 1'b0, 1'b1, 16'h0000, 16'h0000, 16'h0000, 1'b1);
      acc(2'h3, 1'b0, 1'b1, 16'h0001, 16'h0000, em[0][15:0], 1'b0);
      acc(2'h2, 1'b0, 1'b1, 16'h0100, 16'h0000, em[15][15:0], 1'b0);
      acc(2'h3, 1'b0, 1'b1, 16'h0101, 16'h0000, 16'h0000, 1'b0);
      acc(2'h2, 1'b0, 1'b1, 16'h0210, 16'h0000, 16'h0000, 1'b0);
      // clients only read the reserved area, never write it
      acc(2'h3, 1'b0, 1'b1, 16'h0101 + 16'($urandom % 272), 16'h0000, 16'h0000, 1'b0);
      drain();
      chk_wr(0);
      w0 = 16'($urandom);
      acc(2'h3, 1'b1, 1'b1, 16'h0003, w0, 16'h0000, 1'b0);
      em[2] = {16'h0000, w0};
      acc(2'h2, 1'b0, 1'b1, 16'h0003, 16'h0000, w0, 1'b0);
      $display("test areas done");
      for (int k = 0; k < 4; k++)
      begin
         drain();
         high_word_first_i = k[0];
         slow = k[1];
         for (int p = 1; p <= 8; p++)
            for (int s = 0; s < 2; s++)
            begin
               a = 16'h0211 + 16'(2 * (p - 1) + s);
               acc(k[1] ? 2'h2 : 2'h3, 1'b0, s[0], a, 16'h0000, exp_fix(a, k[0]), 1'b0);
            end
      end
      $display("test fixed reads done");
      // 32-bit parameter 2 then string parameter 3, both word orders
      for (int k = 0; k < 4; k++)
      begin
         drain();
         high_word_first_i = k[0];
         a = k[1] ? 16'h0215 : 16'h0213;
         w0 = 16'($urandom);
         w1 = 16'($urandom);
         acc(2'h3, 1'b1, 1'b0, a, w0, 16'h0000, 1'b0);
         acc(2'h3, 1'b1, 1'b1, a + 16'h0001, w1, 16'h0000, 1'b0);
         em[k[1] ? 3 : 2] = (k[0] && !k[1]) ? {w0, w1} : {w1, w0};
         acc(2'h3, 1'b0, 1'b0, a, 16'h0000, exp_fix(a, k[0]), 1'b0);
         acc(2'h3, 1'b0, 1'b1, a + 16'h0001, 16'h0000, exp_fix(a + 16'h0001, k[0]), 1'b0);
      end
      a = 16'h0213;
      drain();
      wc = wr_count;
      acc(2'h3, 1'b1, 1'b1, a, w1, 16'h0000, 1'b0);
      acc(2'h3, 1'b1, 1'b1, a + 16'h0001, w0, 16'h0000, 1'b0);
      acc(2'h3, 1'b1, 1'b0, a, w1, 16'h0000, 1'b0);
      acc(2'h3, 1'b1, 1'b1, 16'h021C, w0, 16'h0000, 1'b0);
      acc(2'h3, 1'b1, 1'b1, 16'h0212, w0, 16'h0000, 1'b0);
      acc(2'h3, 1'b0, 1'b1, a, 16'h0000, exp_fix(a, 1'b1), 1'b0);
      drain();
      chk_wr(wc);
      $display("test writes done");
      results();
   end
endmodule : mpm_top_tb
